// ---- scw_control_regs.sv ----
// Control-word registers 0 to 4, 6, 12 and 13 with the logic they steer
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Low four bits of each word pick register 0, 1, 2, 3, 4, 6, 12 or 13.
// [R2] Host writes zeros into reserved bits of registers 1, 3 and 4.
// [R3] Register 1 bits 27:4 hold the 24-bit main fraction numerator.
// [R4] Aux fraction is register 13 upper part times 2^14 plus register 2.
// [R5] Aux modulus is register 13 bits 17:4 times 2^14 plus register 2.
// [R6] Host keeps aux fraction strictly below aux modulus.
// [R7] Register 0 write resets the modulator unless reset disable is set.
// [R8] Register 3 bit 29 enables resync after the register 12 delay.
// [R9] 24-bit phase value sets output offset as fraction of full turn.
// [R10] With adjust set, each register 0 write adds the phase value.
// [R11] Host avoids divider outputs on the test mux while writing register 0.
// [R12] Bit 26 doubles reference using both edges; else falling edge.
// [R13] Bit 25 inserts a divide-by-two toggle before the detector.
// [R14] 10-bit R counter divides the reference by 1 to 1023.
// [R15] Bit 14 buffers divider select until the next register 0 write.
// [R16] Bits 13:10 select charge pump current.
// [R17] Bit 7 sets detector polarity, one positive, zero negative.
// [R18] Power-down loads counters, resets lock detect, idles pump, outputs.
// [R19] Power-down keeps registers and still accepts new words.
// [R20] Bit 5 three-states the charge pump.
// [R21] Bit 4 holds R counter, N counter and band select in reset.
// [R22] Only complete 32-bit words update; unused codes change nothing.
module scw_control_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_le,
    input wire logic ref_in,
    output logic [23:0] main_fraction_numerator,
    output logic [27:0] aux_fraction,
    output logic [27:0] aux_modulus,
    output logic modulator_reset,
    output logic [23:0] phase_offset,
    output logic phase_resync_pulse,
    output logic [2:0] test_output_select,
    output logic [3:0] pump_current_code,
    output logic pump_three_state_out,
    output logic detector_polarity,
    output logic outputs_enable,
    output logic lock_detect_reset,
    output logic counter_hold,
    output logic [2:0] divider_select,
    output logic pfd_ref,
    output logic pfd_tick
);
    typedef struct packed {
        logic [23:0] main_fraction;
        logic [13:0] aux_fraction_low;
        logic [13:0] aux_modulus_low;
        logic [13:0] aux_fraction_high;
        logic [13:0] aux_modulus_high;
        logic modulator_reset_disable;
        logic phase_resync_enable;
        logic phase_adjust_enable;
        logic [23:0] phase_value;
        logic [2:0] test_select;
        logic reference_doubler_enable;
        logic reference_halver_enable;
        logic [9:0] r_count;
        logic divider_double_buffer_enable;
        logic [3:0] pump_current;
        logic polarity;
        logic soft_power_down;
        logic pump_three_state;
        logic counter_reset;
        logic [2:0] div_pending;
        logic [2:0] div_active;
        logic [19:0] resync_time;
        logic resync_armed;
        logic [19:0] resync_cnt;
        logic resync_pulse;
        logic [23:0] phase_acc;
        logic sd_reset;
    } scw_regs_s;

    localparam scw_regs_s REGS_RESET = '{
        r_count: scw_pkg::RCNT_RESET,
        pump_current: scw_pkg::CP_RESET,
        default: '0
    };

    scw_regs_s st_reg;
    scw_regs_s st_next;
    scw_word_if wbus ();
    logic [3:0] code;
    logic [31:0] w;
    logic wr;

    scw_shifter u_shifter (
        .clock(clock),
        .rst(rst),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_le(ser_le),
        .wbus(wbus)
    );

    assign w = wbus.word;
    assign wr = wbus.valid;
    assign code = wbus.word[scw_pkg::CODE_W-1:0];

    always_comb begin
        st_next = st_reg;
        st_next.sd_reset = 1'b0;
        st_next.resync_pulse = 1'b0;
        if (st_reg.resync_armed && pfd_tick) begin
            // [R8] Resync after delay
            if (st_reg.resync_cnt >= st_reg.resync_time) begin
                st_next.resync_armed = 1'b0;
                st_next.resync_pulse = 1'b1;
                st_next.phase_acc = st_reg.phase_value;
            end else begin
                st_next.resync_cnt = st_reg.resync_cnt + 20'h00001;
            end
        end
        // [R19] Loads continue in power-down
        if (wr) begin
            // [R1] Route by select code
            case (code)
                scw_pkg::CODE_R1: begin
                    // [R3] Main fraction
                    st_next.main_fraction =
                        w[scw_pkg::MAIN_FRACTION_NUMERATOR_LO +: scw_pkg::MAIN_FRACTION_NUMERATOR_W];
                end
                scw_pkg::CODE_R2: begin
                    st_next.aux_fraction_low =
                        w[scw_pkg::AUX_HI_LO +: scw_pkg::AUX_HALF_W];
                    st_next.aux_modulus_low =
                        w[scw_pkg::AUX_LO_LO +: scw_pkg::AUX_HALF_W];
                end
                scw_pkg::CODE_R3: begin
                    st_next.modulator_reset_disable = w[scw_pkg::SD_DIS_BIT];
                    st_next.phase_resync_enable = w[scw_pkg::RESYNC_BIT];
                    st_next.phase_adjust_enable = w[scw_pkg::ADJUST_BIT];
                    st_next.phase_value =
                        w[scw_pkg::PHASE_LO +: scw_pkg::PHASE_W];
                end
                scw_pkg::CODE_R4: begin
                    st_next.test_select = w[scw_pkg::MUX_LO +: scw_pkg::MUX_W];
                    st_next.reference_doubler_enable =
                        w[scw_pkg::DOUBLER_BIT];
                    st_next.reference_halver_enable = w[scw_pkg::HALVER_BIT];
                    st_next.r_count = w[scw_pkg::RCNT_LO +: scw_pkg::RCNT_W];
                    st_next.divider_double_buffer_enable =
                        w[scw_pkg::DBUF_BIT];
                    // [R16] Pump current code
                    st_next.pump_current = w[scw_pkg::CP_LO +: scw_pkg::CP_W];
                    st_next.polarity = w[scw_pkg::POL_BIT];
                    st_next.soft_power_down = w[scw_pkg::PD_BIT];
                    st_next.pump_three_state = w[scw_pkg::TRI_BIT];
                    st_next.counter_reset = w[scw_pkg::CRST_BIT];
                end
                scw_pkg::CODE_R6: begin
                    st_next.div_pending =
                        w[scw_pkg::DIVSEL_LO +: scw_pkg::DIVSEL_W];
                    // [R15] Unbuffered takes effect now
                    if (!st_reg.divider_double_buffer_enable) begin
                        st_next.div_active =
                            w[scw_pkg::DIVSEL_LO +: scw_pkg::DIVSEL_W];
                    end
                end
                scw_pkg::CODE_R12: begin
                    st_next.resync_time =
                        w[scw_pkg::RESYNC_T_LO +: scw_pkg::RESYNC_T_W];
                end
                scw_pkg::CODE_R13: begin
                    st_next.aux_fraction_high =
                        w[scw_pkg::AUX_HI_LO +: scw_pkg::AUX_HALF_W];
                    st_next.aux_modulus_high =
                        w[scw_pkg::AUX_LO_LO +: scw_pkg::AUX_HALF_W];
                end
                scw_pkg::CODE_R0: begin
                    // [R7] Modulator reset on load
                    st_next.sd_reset = ~st_reg.modulator_reset_disable;
                    // [R15] Buffered select transfers
                    st_next.div_active = st_reg.div_pending;
                    // [R10] Phase advance per load
                    if (st_reg.phase_adjust_enable) begin
                        st_next.phase_acc =
                            st_reg.phase_acc + st_reg.phase_value;
                    end else begin
                        // [R9] Offset from phase value
                        st_next.phase_acc = st_reg.phase_value;
                    end
                    // [R8] Arm resync timer
                    if (st_reg.phase_resync_enable) begin
                        st_next.resync_armed = 1'b1;
                        st_next.resync_cnt = 20'h00000;
                    end
                end
                default: begin
                    st_next = st_next;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= REGS_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    scw_ref_div #(
        .R_W(scw_pkg::RCNT_W)
    ) u_ref_div (
        .clock(clock),
        .rst(rst),
        .ref_in(ref_in),
        .doubler_en(st_reg.reference_doubler_enable),
        .halver_en(st_reg.reference_halver_enable),
        .r_value(st_reg.r_count),
        .hold(counter_hold),
        .pfd_tick(pfd_tick),
        .pfd_ref(pfd_ref)
    );

    assign main_fraction_numerator = st_reg.main_fraction;
    // [R4] Aux fraction combine
    assign aux_fraction = {st_reg.aux_fraction_high, st_reg.aux_fraction_low};
    // [R5] Aux modulus combine
    assign aux_modulus = {st_reg.aux_modulus_high, st_reg.aux_modulus_low};
    assign modulator_reset = st_reg.sd_reset;
    assign phase_offset = st_reg.phase_acc;
    assign phase_resync_pulse = st_reg.resync_pulse;
    assign test_output_select = st_reg.test_select;
    assign pump_current_code = st_reg.pump_current;
    // [R20] Pump three-state
    assign pump_three_state_out = st_reg.pump_three_state |
        st_reg.soft_power_down;
    // [R17] Detector polarity
    assign detector_polarity = st_reg.polarity;
    // [R18] Power-down effects
    assign outputs_enable = ~st_reg.soft_power_down;
    assign lock_detect_reset = st_reg.soft_power_down;
    // [R21] Counter and band reset
    assign counter_hold = st_reg.counter_reset | st_reg.soft_power_down;
    assign divider_select = st_reg.div_active;

    // [R1] Register 1 route
    route_r1_a: assert property (@(posedge clock) disable iff (rst) // [R1]
        wr && code == scw_pkg::CODE_R1 |=>
        main_fraction_numerator == $past(w[27:4]))
        else $error("register 1 not loaded");

    // [R22] Unused code keeps state
    unused_code_a: assert property (@(posedge clock) disable iff (rst) // [R22]
        wr && code > scw_pkg::CODE_R4 && code != scw_pkg::CODE_R6 |=>
        $stable(main_fraction_numerator) && $stable(pump_current_code) &&
        $stable(aux_fraction[13:0]))
        else $error("unused code changed a register");

    // [R7] Modulator reset pulse
    sd_reset_a: assert property (@(posedge clock) disable iff (rst) // [R7]
        wr && code == scw_pkg::CODE_R0 |=>
        modulator_reset == !$past(st_reg.modulator_reset_disable) ##1
        !modulator_reset)
        else $error("modulator reset wrong on load");

    // [R10] Phase advance
    phase_adv_a: assert property (@(posedge clock) disable iff (rst) // [R10]
        wr && code == scw_pkg::CODE_R0 && st_reg.phase_adjust_enable &&
        !(st_reg.resync_armed && pfd_tick) |=>
        phase_offset == $past(st_reg.phase_acc) + $past(st_reg.phase_value))
        else $error("phase did not advance");

    // [R15] Buffered divider hold
    dbuf_hold_a: assert property (@(posedge clock) disable iff (rst) // [R15]
        wr && code == scw_pkg::CODE_R6 &&
        st_reg.divider_double_buffer_enable |=> $stable(divider_select))
        else $error("buffered divider select changed early");

    // [R18] Power-down outputs
    pd_outputs_a: assert property (@(posedge clock) disable iff (rst) // [R18]
        st_reg.soft_power_down |-> !outputs_enable && lock_detect_reset &&
        pump_three_state_out && counter_hold)
        else $error("power-down effects missing");

    // [R19] Loads in power-down
    pd_load_a: assert property (@(posedge clock) disable iff (rst) // [R19]
        st_reg.soft_power_down && wr && code == scw_pkg::CODE_R4 |=>
        pump_current_code == $past(w[13:10]) ##1 $stable(pump_current_code))
        else $error("word lost during power-down");

    // [R4] Aux fraction value
    aux_frac_a: assert property (@(posedge clock) disable iff (rst) // [R4]
        wr && code == scw_pkg::CODE_R2 |=> aux_fraction[13:0] ==
        $past(w[31:18]) && aux_modulus[13:0] == $past(w[17:4]))
        else $error("aux low parts wrong");
endmodule : scw_control_regs

// ---- scw_host_model.sv ----
// Host controller model writing words over the serial control port
`timescale 1ns/1ps
module scw_host_model (
    input wire logic clock,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_le
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_le = 1'b0;
    end

    // Whole or partial words
    // Shifts the top n bits MSB first, each clock level held two cycles
    task send(input logic [31:0] w, input int n);
        for (int b = 31; b > 31 - n; b--) begin
            ser_data = w[b];
            ser_clk = 1'b0;
            repeat (2) @(negedge clock);
            ser_clk = 1'b1;
            repeat (2) @(negedge clock);
        end
        ser_clk = 1'b0;
        ser_le = 1'b1;
        repeat (2) @(negedge clock);
        ser_le = 1'b0;
        // Data line is not held after the frame
        ser_data = ~ser_data;
    endtask : send
endmodule : scw_host_model

// ---- scw_pkg.sv ----
// Constants for the synthesizer control-word registers 0 to 4, 6, 12 and 13
package scw_pkg;
    localparam int WORD_W = 32;
    localparam int CODE_W = 4;
    localparam logic [3:0] CODE_R0 = 4'h0;
    localparam logic [3:0] CODE_R1 = 4'h1;
    localparam logic [3:0] CODE_R2 = 4'h2;
    localparam logic [3:0] CODE_R3 = 4'h3;
    localparam logic [3:0] CODE_R4 = 4'h4;
    localparam logic [3:0] CODE_R6 = 4'h6;
    localparam logic [3:0] CODE_R12 = 4'hc;
    localparam logic [3:0] CODE_R13 = 4'hd;
    localparam logic [5:0] BITS_PER_WORD = 6'h20;
    localparam logic [5:0] BIT_COUNT_MAX = 6'h21;
    // Field positions (low bit of each field) and widths
    localparam int MAIN_FRACTION_NUMERATOR_LO = 4;
    localparam int MAIN_FRACTION_NUMERATOR_W = 24;
    localparam int AUX_HALF_W = 14;
    localparam int AUX_HI_LO = 18;
    localparam int AUX_LO_LO = 4;
    localparam int SD_DIS_BIT = 30;
    localparam int RESYNC_BIT = 29;
    localparam int ADJUST_BIT = 28;
    localparam int PHASE_LO = 4;
    localparam int PHASE_W = 24;
    localparam int MUX_LO = 27;
    localparam int MUX_W = 3;
    localparam int DOUBLER_BIT = 26;
    localparam int HALVER_BIT = 25;
    localparam int RCNT_LO = 15;
    localparam int RCNT_W = 10;
    localparam int DBUF_BIT = 14;
    localparam int CP_LO = 10;
    localparam int CP_W = 4;
    localparam int POL_BIT = 7;
    localparam int PD_BIT = 6;
    localparam int TRI_BIT = 5;
    localparam int CRST_BIT = 4;
    localparam int DIVSEL_LO = 21;
    localparam int DIVSEL_W = 3;
    localparam int RESYNC_T_LO = 12;
    localparam int RESYNC_T_W = 20;
    // Values after reset
    localparam logic [9:0] RCNT_RESET = 10'h001;
    localparam logic [3:0] CP_RESET = 4'h0;
endpackage : scw_pkg

// ---- scw_ref_div.sv ----
// Reference doubler, R counter and divide-by-two path
`timescale 1ns/1ps
module scw_ref_div #(
    parameter int R_W = 10
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ref_in,
    input wire logic doubler_en,
    input wire logic halver_en,
    input wire logic [R_W-1:0] r_value,
    input wire logic hold,
    output logic pfd_tick,
    output logic pfd_ref
);
    typedef struct packed {
        logic ref_prev;
        logic [R_W-1:0] cnt;
        logic half;
        logic tick;
        logic out;
    } scw_rdiv_s;

    scw_rdiv_s st_reg;
    scw_rdiv_s st_next;
    logic edge_act;
    logic [R_W-1:0] last;

    always_comb begin
        st_next = st_reg;
        st_next.ref_prev = ref_in;
        st_next.tick = 1'b0;
        // [R12] Active reference edges
        edge_act = doubler_en ? (ref_in ^ st_reg.ref_prev)
                              : (st_reg.ref_prev & ~ref_in);
        // [R14] Ratio 1 to 1023
        last = (r_value == '0) ? '0 : r_value - 1'b1;
        if (hold) begin
            st_next.cnt = '0;
            st_next.half = 1'b0;
            st_next.out = 1'b0;
        end else if (edge_act) begin
            if (st_reg.cnt >= last) begin
                st_next.cnt = '0;
                // [R13] Toggle divide-by-two
                st_next.half = halver_en ? ~st_reg.half : st_reg.half;
                st_next.tick = ~halver_en | ~st_reg.half;
                st_next.out = halver_en ? ~st_reg.half : 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt + 1'b1;
                st_next.out = halver_en ? st_reg.half : 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pfd_tick = st_reg.tick;
    assign pfd_ref = st_reg.out;

    // [R21] Counter held in reset
    hold_clear_a: assert property (@(posedge clock) disable iff (rst) // [R21]
        hold |=> st_reg.cnt == '0 && !st_reg.tick)
        else $error("R counter ran while held");
endmodule : scw_ref_div

// ---- scw_shifter.sv ----
// Serial control port shifter producing 32-bit words
`timescale 1ns/1ps
module scw_shifter (
    input wire logic clock,
    input wire logic rst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_le,
    scw_word_if.src wbus
);
    typedef struct packed {
        logic clk_prev;
        logic le_prev;
        logic [31:0] shift;
        logic [5:0] count;
        logic [31:0] word;
        logic valid;
    } scw_shift_s;

    scw_shift_s st_reg;
    scw_shift_s st_next;

    always_comb begin
        st_next = st_reg;
        st_next.clk_prev = ser_clk;
        st_next.le_prev = ser_le;
        st_next.valid = 1'b0;
        if (ser_clk && !st_reg.clk_prev) begin
            st_next.shift = {st_reg.shift[30:0], ser_data};
            if (st_reg.count != scw_pkg::BIT_COUNT_MAX) begin
                st_next.count = st_reg.count + 6'h01;
            end
        end
        if (ser_le && !st_reg.le_prev) begin
            // [R22] Whole words only
            if (st_reg.count == scw_pkg::BITS_PER_WORD) begin
                st_next.word = st_reg.shift;
                st_next.valid = 1'b1;
            end
            st_next.count = 6'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wbus.word = st_reg.word;
    assign wbus.valid = st_reg.valid;

    // [R22] Word length check
    word_len_a: assert property (@(posedge clock) disable iff (rst) // [R22]
        st_reg.valid |-> $past(st_reg.count) == scw_pkg::BITS_PER_WORD)
        else $error("word accepted without 32 bits");
endmodule : scw_shifter

// ---- scw_word_if.sv ----
// Hand-off of a complete serial control word
`timescale 1ns/1ps
interface scw_word_if;
    logic [31:0] word;
    logic valid;
    modport src (output word, output valid);
    modport dst (input word, input valid);
endinterface : scw_word_if

// ---- tb.sv ----
// Self-checking testbench for the control-word registers
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ref_in = 1'b0;
    logic ser_clk, ser_data, ser_le;
    logic [23:0] mfn, phase_offset;
    logic [27:0] aux_fraction, aux_modulus;
    logic modulator_reset, phase_resync_pulse, pump_three_state_out;
    logic detector_polarity, outputs_enable, lock_detect_reset;
    logic counter_hold, pfd_ref, pfd_tick;
    logic [2:0] test_output_select, divider_select;
    logic [3:0] pump_current_code;
    int fail_count = 0, compares = 0, ticks = 0, falls = 0;
    int mr_cnt = 0, rs_cnt = 0, ph = 0, hi = 0;

    always #50 clock = ~clock;

    scw_control_regs DUT (.clock(clock), .rst(rst), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_le(ser_le), .ref_in(ref_in),
        .main_fraction_numerator(mfn), .aux_fraction(aux_fraction),
        .aux_modulus(aux_modulus), .modulator_reset(modulator_reset),
        .phase_offset(phase_offset),
        .phase_resync_pulse(phase_resync_pulse),
        .test_output_select(test_output_select),
        .pump_current_code(pump_current_code),
        .pump_three_state_out(pump_three_state_out),
        .detector_polarity(detector_polarity),
        .outputs_enable(outputs_enable),
        .lock_detect_reset(lock_detect_reset),
        .counter_hold(counter_hold), .divider_select(divider_select),
        .pfd_ref(pfd_ref), .pfd_tick(pfd_tick));

    scw_host_model HOST (.clock(clock), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_le(ser_le));

    // Free-running reference, period eight clocks
    always @(negedge clock) begin
        ph = (ph + 1) % 4;
        if (ph == 0) begin
            if (ref_in) falls++;
            ref_in <= ~ref_in;
        end
    end

    always @(posedge clock) begin
        if (pfd_tick === 1'b1) ticks++;
        if (pfd_ref === 1'b1) hi++;
        if (modulator_reset === 1'b1) mr_cnt++;
        if (phase_resync_pulse === 1'b1) rs_cnt++;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task final_report;
        $display("mismatches %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    task wr(input logic [31:0] w);
        HOST.send(w, 32);
        repeat (3) @(negedge clock);
    endtask : wr

    task done(input string s);
        $display("test %s done", s);
    endtask : done

    function automatic logic [31:0] r4(input logic [2:0] mux,
        input logic dbl, hlv, input logic [9:0] r, input logic dbuf,
        input logic [3:0] cp, input logic pol, pd, tri3, crst);
        r4 = {2'b00, mux, dbl, hlv, r, dbuf, cp, 2'b00, pol, pd, tri3,
              crst, 4'h4};
    endfunction : r4

    // Counts detector ticks against reference falls in a window
    task meas(input logic dbl, hlv, input logic [9:0] r,
              input logic crst);
        int e;
        wr(r4(3'h0, dbl, hlv, r, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, crst));
        repeat (40) @(negedge clock);
        ticks = 0;
        falls = 0;
        hi = 0;
        repeat (400) @(negedge clock);
        e = crst ? 0 : falls * (dbl ? 2 : 1) / (r * (hlv ? 2 : 1));
        compares++;
        if (ticks > e + 1 || ticks + 1 < e) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, ticks, e);
        end
        if (hlv) begin
            compares++;
            if (hi < 170 || hi > 230) begin
                fail_count++;
                $display("ERROR t=%0t got %h exp %h", $time, hi, 200);
            end
        end
    endtask : meas

    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        final_report();
    end

    initial begin
        int n;
        logic [3:0] k;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        chk(counter_hold, 0);
        chk(outputs_enable, 1);
        done("reset");
        wr({4'h0, 24'hffffff, 4'h1});
        chk(mfn, 24'hffffff);
        wr({4'h0, 24'h5a5a5a, 4'h1});
        chk(mfn, 24'h5a5a5a);
        for (int c = 5; c < 16; c++)
            if (c != 6 && c != 12 && c != 13) wr({4'h0, 24'h123456, 4'(c)});
        HOST.send({4'h0, 24'h0f0f0f, 4'h1}, 31);
        repeat (3) @(negedge clock);
        chk(mfn, 24'h5a5a5a);
        done("routing");
        wr({14'h1234, 14'h3fff, 4'h2});
        wr({14'h0002, 14'h0005, 4'hd});
        chk(aux_fraction, (32'd2 << 14) + 32'h1234);
        chk(aux_modulus, (32'd5 << 14) + 32'h3fff);
        done("aux");
        // Test output left at zero while register 0 is written
        wr({4'h0, 24'h100000, 4'h3});
        mr_cnt = 0;
        wr(32'h0);
        chk(mr_cnt, 1);
        chk(phase_offset, 24'h100000);
        wr({4'h5, 24'h100000, 4'h3});
        mr_cnt = 0;
        wr(32'h0);
        wr(32'h0);
        chk(mr_cnt, 0);
        chk(phase_offset, 24'h300000);
        wr({4'h5, 24'hf00000, 4'h3});
        wr(32'h0);
        chk(phase_offset, 24'h200000);
        done("phase");
        wr({20'h00020, 8'h00, 4'hc});
        wr({4'h2, 24'h0abcde, 4'h3});
        rs_cnt = 0;
        wr(32'h0);
        wr({4'h2, 24'h054321, 4'h3});
        chk(rs_cnt, 0);
        chk(phase_offset, 24'h0abcde);
        for (n = 0; n < 400 && rs_cnt == 0; n++) @(negedge clock);
        if (rs_cnt == 0) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, rs_cnt, 1);
            final_report();
        end
        repeat (50) @(negedge clock);
        chk(rs_cnt, 1);
        chk(phase_offset, 24'h054321);
        done("resync");
        wr(r4(3'h0, 0, 0, 10'h1, 1, 4'h0, 0, 0, 0, 0));
        wr({4'h0, 4'ha, 3'h5, 17'h0, 4'h6});
        chk(divider_select, 3'h0);
        wr(32'h0);
        chk(divider_select, 3'h5);
        wr(r4(3'h0, 0, 0, 10'h1, 0, 4'h0, 0, 0, 0, 0));
        wr({4'h0, 4'ha, 3'h3, 17'h0, 4'h6});
        chk(divider_select, 3'h3);
        done("buffer");
        for (int i = 0; i < 16; i++) begin
            k = 4'(i);
            wr(r4(k[2:0], 0, 0, 10'h1, 0, k, k[0], k[1], k[2], k[3]));
            chk(test_output_select, k[2:0]);
            chk(pump_current_code, k);
            chk(detector_polarity, k[0]);
            chk(lock_detect_reset, k[1]);
            chk(outputs_enable, !k[1]);
            chk(pump_three_state_out, k[1] | k[2]);
            chk(counter_hold, k[1] | k[3]);
        end
        wr({4'h0, 24'h777777, 4'h1});
        chk(mfn, 24'h777777);
        chk(pump_current_code, 4'hf);
        done("fields");
        meas(0, 0, 10'h1, 0);
        meas(0, 0, 10'h3, 0);
        meas(1, 0, 10'h3, 0);
        meas(0, 1, 10'h3, 0);
        meas(0, 0, 10'h2, 1);
        done("reference");
        final_report();
    end
endmodule : tb
